// ===== rtl/mcu_pkg.sv
// constants shared by the slave microcontroller core
package mcu_pkg;
  // program counter, memory, synchroniser and prescaler sizes
  localparam int PC_W = 11;
  localparam int ROM_DEPTH = 2048;
  localparam int RAM_DEPTH = 256;
  localparam int STK_DEPTH = 8;
  localparam int SYNC_W = 23;
  localparam int TIMER_PRESCALE = 32;
  // host register byte offsets
  localparam logic [4:0] REG_DATA = 5'h00;
  localparam logic [4:0] REG_STAT = 5'h04;
  localparam logic [4:0] REG_PADDR = 5'h08;
  localparam logic [4:0] REG_PDATA = 5'h0C;
  localparam logic [4:0] REG_CTRL = 5'h10;
  localparam logic [4:0] REG_PC = 5'h14;
  // field positions
  localparam int ST_OBF = 0;
  localparam int ST_IBF = 1;
  localparam int ST_F0 = 2;
  localparam int ST_F1 = 3;
  localparam int CTRL_RUN = 0;
  localparam int PSW_CY = 7;
  localparam int PSW_F0 = 5;
  localparam int PSW_BS = 4;
  localparam int P2_OBF = 4;
  localparam int P2_IBFN = 5;
  localparam int P2_DRQ = 6;
  // reset values and fixed addresses
  localparam logic [7:0] PSW_RST = 8'h08;
  localparam logic [7:0] BANK1_BASE = 8'h18;
  localparam logic [PC_W-1:0] VEC_RESET = 11'h000;
  localparam logic [PC_W-1:0] VEC_IBF = 11'h003;
  localparam logic [PC_W-1:0] VEC_TMR = 11'h007;
  localparam logic [2:0] PAGE3 = 3'h3;
  // opcodes, single byte single cycle
  localparam logic [7:0] OP_IN_DBB = 8'h01, OP_OUT_DBB = 8'h02, OP_MOV_STS = 8'h03;
  localparam logic [7:0] OP_MOV_AT = 8'h04, OP_MOV_TA = 8'h05, OP_STRT_T = 8'h06;
  localparam logic [7:0] OP_START_EVENT_COUNTING = 8'h07, OP_STOP = 8'h60, OP_EN_TI = 8'h61;
  localparam logic [7:0] OP_DIS_TI = 8'h62, OP_EN_DMA = 8'h63, OP_ENI = 8'h64;
  localparam logic [7:0] OP_INPUT_FULL_INTERRUPT_DISABLE = 8'h65, OP_EN_FLAGS = 8'h66, OP_SEL_RB0 = 8'h67;
  localparam logic [7:0] OP_SEL_RB1 = 8'h68, OP_CLR_F0 = 8'h6D, OP_CPL_F0 = 8'h6E;
  localparam logic [7:0] OP_CLR_F1 = 8'h6F, OP_CPL_F1 = 8'h70, OP_CLR_A = 8'h72;
  localparam logic [7:0] OP_MOV_APSW = 8'h73;
  // one byte two cycle, and immediate forms
  localparam logic [7:0] OP_CURRENT_PAGE_LOOKUP = 8'h69, OP_PAGE_THREE_LOOKUP = 8'h6A, OP_RET = 8'h6B;
  localparam logic [7:0] OP_RETURN_RESTORE_STATUS = 8'h6C, OP_MOV_AI = 8'h71;
  // groups: low bits select register, pointer, port or target page
  localparam logic [4:0] G_MOV_AR = 5'h01, G_MOV_RA = 5'h02, G_ADD_AR = 5'h03;
  localparam logic [4:0] G_DECREMENT_BRANCH_NONZERO = 5'h04, G_MOV_RI = 5'h05, G_CALL = 5'h10, G_JMP = 5'h11;
  localparam logic [6:0] G_MOV_AIND = 7'h18, G_MOV_INDA = 7'h19, G_DIGIT_EXCHANGE = 7'h1A;
  localparam logic [6:0] G_MOV_INDI = 7'h1B;
  localparam logic [5:0] G_IN_P = 6'h10, G_OUTL_P = 6'h11, G_ANL_PI = 6'h12;
  localparam logic [5:0] G_ORL_PI = 6'h13, G_EXP_RD = 6'h14;
  // conditional branches in page
  localparam logic [7:0] OP_JTF = 8'h90, OP_BRANCH_INPUT_EMPTY = 8'h91, OP_BRANCH_OUTPUT_FULL = 8'h92;
  localparam logic [7:0] OP_JT0 = 8'h93, OP_JNT0 = 8'h94, OP_JT1 = 8'h95;
  localparam logic [7:0] OP_JNT1 = 8'h96, OP_JF0 = 8'h97, OP_JF1 = 8'h98;
  typedef enum logic {S_FETCH, S_SECOND} cyc_t;
  typedef enum logic [1:0] {TM_STOP, TM_TIMER, TM_COUNT} tmode_t;
endpackage

// ===== rtl/slave_mcu_core.sv
// slave microcontroller core with host buffer, timer and expander
//
// Our own choices: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ns
module slave_mcu_core #(
  parameter int CYC_DIV = 4
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic test0,
  input wire logic test1,
  input wire logic dackN,
  input wire logic [7:0] port1In,
  input wire logic [7:0] port2In,
  input wire logic [3:0] expIn,
  output logic [7:0] port1Out,
  output logic [7:0] port2Out,
  output logic [1:0] expPort,
  output logic [1:0] expCmd,
  output logic [3:0] expData,
  output logic expStrobe
);
  import mcu_pkg::*;

  logic [7:0] rom [ROM_DEPTH]; // program store, loaded by host
  logic [7:0] ram [RAM_DEPTH]; // data memory with both banks
  logic [PC_W+3:0] stk [STK_DEPTH]; // {psw hi, pc}
  logic [SYNC_W-1:0] s1_q, s2_q, s3_q, stab_q; // pin synchroniser
  logic [SYNC_W-1:0] stabNext; // filtered pins as they settle at this edge
  logic [$clog2(CYC_DIV)-1:0] div_q; // machine cycle divider
  logic tick; // one machine cycle enable
  cyc_t state_q;
  logic [PC_W-1:0] pc_q, progAddr_q;
  logic [7:0] op_q, acc_q, psw_q, p2_q, tmr_q, inBuf_q, outBuf_q;
  logic [3:0] stsHi_q;
  logic run_q, ibf_q, obf_q, f1_q, drq_q, tf_q, tPend_q, t1Prev_q;
  logic ibfIntEn_q, tIntEn_q, flagsEn_q, dmaEn_q, inSvc_q;
  tmode_t tMode_q;
  logic [4:0] pre_q; // timer prescaler
  // decode helpers
  logic [7:0] curOp, imm, rAddr, pAddr, iAddr, rVal, iVal, portCur, status;
  logic t0S, t1S, dackS, p2Sel, brCond, intTake, ibfReq;
  logic fetchExec, secExec, hostWr, hostRd, tmrInc, tmrOvf;
  logic [31:0] rdMux;

  function automatic logic twoCyc(input logic [7:0] o);
    twoCyc = o[7] || (o[7:3] == G_DECREMENT_BRANCH_NONZERO) || (o[7:3] == G_MOV_RI) || (o[7:1] == G_MOV_INDI)
      || (o[7:5] == 3'b010) || (o >= OP_CURRENT_PAGE_LOOKUP && o <= OP_RETURN_RESTORE_STATUS) || (o == OP_MOV_AI);
  endfunction

  ////////////////////////////////////////////////////////////////////
  // pin synchroniser: a change counts once stages two and three agree
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      stab_q <= '0;
    end
    else
    begin
      s1_q <= {test0, test1, dackN, port1In, port2In, expIn};
      s2_q <= s1_q;
      s3_q <= s2_q;
      stab_q <= stabNext;
    end
  end
  // next filter value, so a read late in a cycle still sees the settled pin
  assign stabNext = ((s2_q ~^ s3_q) & s3_q) | ((s2_q ^ s3_q) & stab_q);
  assign t0S = stab_q[22];
  assign t1S = stab_q[21];
  assign dackS = stab_q[20];

  ////////////////////////////////////////////////////////////////////
  // machine cycle enable from mclk
  always_ff @(posedge mclk)
  begin
    if (reset || div_q == ($clog2(CYC_DIV))'(CYC_DIV - 1))
      div_q <= '0;
    else
      div_q <= div_q + 1'b1;
  end
  assign tick = run_q && (div_q == ($clog2(CYC_DIV))'(CYC_DIV - 1));

  ////////////////////////////////////////////////////////////////////
  // combinational decode
  always_comb
  begin
    curOp = (state_q == S_FETCH) ? rom[pc_q] : op_q;
    imm = rom[pc_q]; // in second cycle pc points at operand
    rAddr = (psw_q[PSW_BS] ? BANK1_BASE : 8'h00) + {5'h0, curOp[2:0]};
    pAddr = (psw_q[PSW_BS] ? BANK1_BASE : 8'h00) + {7'h0, curOp[0]};
    rVal = ram[rAddr];
    iAddr = ram[pAddr];
    iVal = ram[iAddr];
    p2Sel = (curOp[1:0] == 2'd2);
    portCur = p2Sel ? p2_q : port1Out;
    status = {stsHi_q, f1_q, psw_q[PSW_F0], ibf_q, obf_q};
    unique case (op_q)
      OP_JTF: brCond = tf_q;
      OP_BRANCH_INPUT_EMPTY: brCond = !ibf_q;
      OP_BRANCH_OUTPUT_FULL: brCond = obf_q;
      OP_JT0: brCond = t0S;
      OP_JNT0: brCond = !t0S;
      OP_JT1: brCond = t1S;
      OP_JNT1: brCond = !t1S;
      OP_JF0: brCond = psw_q[PSW_F0];
      OP_JF1: brCond = f1_q;
      default: brCond = 1'b0;
    endcase
  end
  // input-full request has priority over the timer
  assign ibfReq = ibfIntEn_q && ibf_q;
  assign intTake = (state_q == S_FETCH) && !inSvc_q && (ibfReq || (tIntEn_q && tPend_q));
  assign fetchExec = tick && (state_q == S_FETCH) && !intTake;
  assign secExec = tick && (state_q == S_SECOND);

  ////////////////////////////////////////////////////////////////////
  // instruction execution
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      state_q <= S_FETCH;
      pc_q <= VEC_RESET;
      op_q <= 8'h00;
      acc_q <= 8'h00;
      psw_q <= PSW_RST;
      port1Out <= 8'hFF;
      p2_q <= 8'hFF;
      {ibfIntEn_q, tIntEn_q, flagsEn_q, dmaEn_q, inSvc_q} <= '0;
      {expPort, expCmd, expData, expStrobe} <= '0;
    end
    else if (tick && intTake)
    begin
      // interrupt entry: save pc and status, go to vector
      stk[psw_q[2:0]] <= {psw_q[7:4], pc_q};
      psw_q[2:0] <= psw_q[2:0] + 3'd1;
      pc_q <= ibfReq ? VEC_IBF : VEC_TMR;
      inSvc_q <= 1'b1;
    end
    else if (fetchExec)
    begin
      pc_q <= pc_q + 1'b1;
      if (twoCyc(curOp))
      begin
        op_q <= curOp;
        state_q <= S_SECOND;
        // expander strobe spans the second cycle
        if (curOp[7:4] == 4'h5)
        begin
          expPort <= curOp[1:0];
          expCmd <= curOp[3:2];
          expData <= acc_q[3:0];
          expStrobe <= 1'b1;
        end
      end
      else
      begin
        casez (curOp)
          OP_IN_DBB: acc_q <= inBuf_q;
          OP_MOV_AT: acc_q <= tmr_q;
          OP_EN_TI: tIntEn_q <= 1'b1;
          OP_DIS_TI: tIntEn_q <= 1'b0;
          OP_EN_DMA: dmaEn_q <= 1'b1;
          OP_ENI: ibfIntEn_q <= 1'b1;
          OP_INPUT_FULL_INTERRUPT_DISABLE: ibfIntEn_q <= 1'b0;
          OP_EN_FLAGS: flagsEn_q <= 1'b1;
          OP_SEL_RB0: psw_q[PSW_BS] <= 1'b0;
          OP_SEL_RB1: psw_q[PSW_BS] <= 1'b1;
          OP_CLR_F0: psw_q[PSW_F0] <= 1'b0;
          OP_CPL_F0: psw_q[PSW_F0] <= !psw_q[PSW_F0];
          OP_CLR_A: acc_q <= 8'h00;
          OP_MOV_APSW: acc_q <= psw_q;
          {G_MOV_AR, 3'b???}: acc_q <= rVal;
          {G_MOV_RA, 3'b???}: ram[rAddr] <= acc_q;
          {G_ADD_AR, 3'b???}: {psw_q[PSW_CY], acc_q} <= {1'b0, acc_q} + {1'b0, rVal};
          {G_MOV_AIND, 1'b?}: acc_q <= iVal;
          {G_MOV_INDA, 1'b?}: ram[iAddr] <= acc_q;
          {G_DIGIT_EXCHANGE, 1'b?}:
          begin
            acc_q <= {acc_q[7:4], iVal[3:0]};
            ram[iAddr] <= {iVal[7:4], acc_q[3:0]};
          end
          default: ; // unassigned codes act as no operation
        endcase
      end
    end
    else if (secExec)
    begin
      state_q <= S_FETCH;
      expStrobe <= 1'b0;
      casez (op_q)
        OP_MOV_AI:
        begin
          acc_q <= imm;
          pc_q <= pc_q + 1'b1;
        end
        {G_MOV_RI, 3'b???}:
        begin
          ram[rAddr] <= imm;
          pc_q <= pc_q + 1'b1;
        end
        {G_MOV_INDI, 1'b?}:
        begin
          ram[iAddr] <= imm;
          pc_q <= pc_q + 1'b1;
        end
        {G_DECREMENT_BRANCH_NONZERO, 3'b???}:
        begin
          ram[rAddr] <= rVal - 8'd1;
          pc_q <= (rVal != 8'd1) ? {pc_q[10:8], imm} : pc_q + 1'b1;
        end
        {G_IN_P, 2'b??}: acc_q <= p2Sel ? stab_q[11:4] : stab_q[19:12];
        {G_OUTL_P, 2'b??}:
          if (p2Sel) p2_q <= acc_q;
          else port1Out <= acc_q;
        {G_ANL_PI, 2'b??}, {G_ORL_PI, 2'b??}:
        begin
          if (p2Sel) p2_q <= op_q[2] ? (portCur | imm) : (portCur & imm);
          else port1Out <= op_q[2] ? (portCur | imm) : (portCur & imm);
          pc_q <= pc_q + 1'b1;
        end
        // expander read lands in second cycle
        {G_EXP_RD, 2'b??}: acc_q <= {4'h0, stabNext[3:0]}; // nibble settles on this edge
        OP_CURRENT_PAGE_LOOKUP: acc_q <= rom[{pc_q[10:8], acc_q}];
        OP_PAGE_THREE_LOOKUP: acc_q <= rom[{PAGE3, acc_q}];
        // returns, restoring status on the second form
        OP_RET, OP_RETURN_RESTORE_STATUS:
        begin
          pc_q <= stk[psw_q[2:0] - 3'd1][PC_W-1:0];
          psw_q[2:0] <= psw_q[2:0] - 3'd1;
          if (op_q == OP_RETURN_RESTORE_STATUS)
          begin
            psw_q[7:4] <= stk[psw_q[2:0] - 3'd1][PC_W+3:PC_W];
            inSvc_q <= 1'b0;
          end
        end
        // call pushes return address and status
        {G_CALL, 3'b???}:
        begin
          stk[psw_q[2:0]] <= {psw_q[7:4], pc_q + 1'b1};
          psw_q[2:0] <= psw_q[2:0] + 3'd1;
          pc_q <= {op_q[2:0], imm};
        end
        {G_JMP, 3'b???}: pc_q <= {op_q[2:0], imm};
        // conditional target replaces low byte only
        default:
          if (op_q >= OP_JTF && op_q <= OP_JF1)
            pc_q <= brCond ? {pc_q[10:8], imm} : pc_q + 1'b1;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // host buffer flags; hardware set wins over the clear
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      {ibf_q, obf_q, f1_q, drq_q} <= '0;
      inBuf_q <= 8'h00;
      outBuf_q <= 8'h00;
      stsHi_q <= 4'h0;
    end
    else
    begin
      if (hostWr && (address == REG_DATA || address == REG_STAT))
      begin
        ibf_q <= 1'b1;
        inBuf_q <= writedata[7:0];
        f1_q <= (address == REG_STAT); // command versus data
      end
      else
      begin
        // consuming the input clears the flag
        if (fetchExec && curOp == OP_IN_DBB) ibf_q <= 1'b0;
        if (fetchExec && curOp == OP_CLR_F1) f1_q <= 1'b0;
        if (fetchExec && curOp == OP_CPL_F1) f1_q <= !f1_q;
      end
      // output buffer load sets full flag
      if (fetchExec && curOp == OP_OUT_DBB)
      begin
        outBuf_q <= acc_q;
        obf_q <= 1'b1;
        drq_q <= dmaEn_q;
      end
      else
      begin
        if (hostRd && address == REG_DATA) obf_q <= 1'b0;
        if (!dackS) drq_q <= 1'b0; // acknowledge ends the request
      end
      // only the upper nibble is written
      if (fetchExec && curOp == OP_MOV_STS) stsHi_q <= acc_q[7:4];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // port 2 pins, flag and dma lines overlay when enabled
  always_ff @(posedge mclk)
  begin
    if (reset)
      port2Out <= 8'hFF;
    else
    begin
      port2Out <= p2_q;
      if (flagsEn_q)
      begin
        port2Out[P2_OBF] <= obf_q;
        port2Out[P2_IBFN] <= !ibf_q;
      end
      if (dmaEn_q) port2Out[P2_DRQ] <= drq_q;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // timer/counter; counting continues while the core runs
  assign tmrInc = ((tMode_q == TM_TIMER) && tick && pre_q == 5'(TIMER_PRESCALE - 1))
    || ((tMode_q == TM_COUNT) && t1Prev_q && !t1S);
  assign tmrOvf = tmrInc && tmr_q == 8'hFF && !(fetchExec && curOp == OP_MOV_TA);
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      tMode_q <= TM_STOP;
      {tmr_q, pre_q, tf_q, tPend_q, t1Prev_q} <= '0;
    end
    else
    begin
      t1Prev_q <= t1S;
      if (tMode_q == TM_TIMER && tick) pre_q <= pre_q + 5'd1;
      if (fetchExec && curOp == OP_STRT_T)
      begin
        tMode_q <= TM_TIMER;
        pre_q <= 5'd0;
      end
      if (fetchExec && curOp == OP_START_EVENT_COUNTING) tMode_q <= TM_COUNT;
      if (fetchExec && curOp == OP_STOP) tMode_q <= TM_STOP;
      if (fetchExec && curOp == OP_MOV_TA) tmr_q <= acc_q;
      else if (tmrInc) tmr_q <= tmr_q + 8'd1;
      if (tmrOvf) tf_q <= 1'b1;
      else if (secExec && op_q == OP_JTF) tf_q <= 1'b0;
      if (tmrOvf) tPend_q <= 1'b1;
      else if ((tick && intTake && !ibfReq) || (fetchExec && curOp == OP_DIS_TI))
        tPend_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // avalon slave, one wait state per access
  assign hostWr = write && !waitrequest && byteenable[0];
  assign hostRd = read && !waitrequest;
  always_comb
  begin
    unique case (address)
      REG_DATA: rdMux = {24'h0, outBuf_q};
      REG_STAT: rdMux = {24'h0, status};
      REG_PADDR: rdMux = {21'h0, progAddr_q};
      REG_CTRL: rdMux = {31'h0, run_q};
      REG_PC: rdMux = {21'h0, pc_q};
      default: rdMux = 32'h0; // unmapped reads zero
    endcase
  end
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      waitrequest <= 1'b1;
      readdata <= 32'h0;
      run_q <= 1'b0;
      progAddr_q <= '0;
    end
    else
    begin
      waitrequest <= 1'b1;
      if ((read || write) && waitrequest)
      begin
        waitrequest <= 1'b0;
        // a write leaves the last read data standing
        if (read) readdata <= rdMux;
      end
      if (hostWr && address == REG_PADDR) progAddr_q <= writedata[PC_W-1:0];
      if (hostWr && address == REG_PDATA) progAddr_q <= progAddr_q + 1'b1;
      if (hostWr && address == REG_CTRL) run_q <= writedata[CTRL_RUN];
    end
  end
  // program store has no reset
  always_ff @(posedge mclk)
  begin
    if (hostWr && address == REG_PDATA) rom[progAddr_q] <= writedata[7:0];
  end
endmodule

// ===== tb/slave_mcu_core_asserts.sv
// checker for the host bus and expander pins of the core
`timescale 1ns/1ns
module slave_mcu_core_asserts #(
  parameter int CYC_DIV = 4
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic [7:0] port1Out,
  input wire logic [7:0] port2Out,
  input wire logic [1:0] expPort,
  input wire logic [1:0] expCmd,
  input wire logic [3:0] expData,
  input wire logic expStrobe
);
  import mcu_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////////////////////
  // cycles the strobe has been high, cleared while low
  logic [7:0] strobeCnt_q;
  always_ff @(posedge mclk)
  begin
    if (reset || !expStrobe)
      strobeCnt_q <= 8'h00;
    else
      strobeCnt_q <= strobeCnt_q + 8'h01;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // a seen request is answered in the next cycle
  a_wait_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("request not answered next cycle");
  // the answer lasts one cycle only
  a_wait_single: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low for more than one cycle");
  // no answer without a request
  a_wait_idle: assert property (!(read || write) && waitrequest |=> waitrequest)
    else $error("waitrequest dropped without a request");
  // places above the PC register read as zero
  a_unmapped_zero: assert property (read && !waitrequest && address > REG_PC |-> readdata == 32'h0)
    else $error("unmapped read not zero");
  // status byte sits in the low bits
  a_status_width: assert property (read && !waitrequest && address == REG_STAT
    |-> readdata[31:8] == 24'h0)
    else $error("status read has upper bits set");
  // read data only move after a seen read
  a_data_hold: assert property ($changed(readdata) |-> $past(read) && $past(waitrequest))
    else $error("readdata changed without a read");
  a_strobe_len: assert property ($fell(expStrobe) |-> strobeCnt_q == 8'(CYC_DIV))
    else $error("expander strobe length wrong");
  // expander command held while strobed
  a_exp_stable: assert property (expStrobe && $past(expStrobe)
    |-> $stable(expCmd) && $stable(expPort) && $stable(expData))
    else $error("expander command moved during strobe");
  // pins and bus idle when reset ends
  a_reset_idle: assert property ($fell(reset) |-> waitrequest && readdata == 32'h0
    && port1Out == 8'hFF && port2Out == 8'hFF && !expStrobe)
    else $error("outputs not idle after reset");
endmodule

bind slave_mcu_core slave_mcu_core_asserts #(.CYC_DIV(CYC_DIV)) u_chk (
  .mclk(mclk),
  .reset(reset),
  .address(address),
  .read(read),
  .write(write),
  .readdata(readdata),
  .waitrequest(waitrequest),
  .port1Out(port1Out),
  .port2Out(port2Out),
  .expPort(expPort),
  .expCmd(expCmd),
  .expData(expData),
  .expStrobe(expStrobe)
);

// ===== tb/expander_model.sv
// behavioural four-port nibble expander on the far side of the core
`timescale 1ns/1ns
module expander_model (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [1:0] expPort,
  input wire logic [1:0] expCmd,
  input wire logic [3:0] expData,
  input wire logic expStrobe,
  output logic [3:0] expIn,
  output logic [3:0] port0Value
);
  // latched nibble of each port
  logic [3:0] store_q [4];
  // strobe of the previous cycle, for the end of an operation
  logic strobe_q;
  // update at the strobe's end, when command and data have stood a whole cycle
  always_ff @(posedge mclk)
  begin
    strobe_q <= expStrobe;
    if (reset)
      store_q <= '{default: 4'h0};
    else if (strobe_q && !expStrobe)
    begin
      case (expCmd)
        2'h1: store_q[expPort] <= expData;
        2'h2: store_q[expPort] <= store_q[expPort] & expData;
        2'h3: store_q[expPort] <= store_q[expPort] | expData;
        default: ;
      endcase
    end
  end
  // drive only during a read strobe; otherwise the inverse, so stale sampling shows
  assign expIn = (expStrobe && expCmd == 2'h0) ? store_q[expPort] : ~store_q[expPort];
  assign port0Value = store_q[0];
endmodule

// ===== tb/tb.sv
// self-checking bench running a small program through the core
`timescale 1ns/1ns
module tb;
  import mcu_pkg::*;
  logic mclk, reset, read, write, waitrequest, expStrobe;
  logic [4:0] address;
  logic [31:0] writedata, readdata, rdVal;
  logic [3:0] byteenable, expIn, expData, expSeen;
  logic [7:0] port1Out, port2Out;
  logic [1:0] expPort, expCmd;
  int badCount, cmpCount;
  // program image, four bytes to a word, first byte highest
  logic [31:0] prog [34] = '{32'h91000103, 32'h02920591, 32'h07010292, 32'h0B710028,
    32'h03290719, 32'h20130292, 32'h17682855, 32'h6728AA68, 32'h08029222, 32'h71106A02,
    32'h922871F0, 32'h6902922E, 32'h6D6E9738, 32'h71EE883A, 32'h71C30292, 32'h3B710954,
    32'h710C5850, 32'h02924571, 32'hA544480F, 32'h4C3071FF, 32'h05069056, 32'h8852905E,
    32'h60717702, 32'h925C8860, 32'h713C36A7, 32'h34029266, 32'h3002926A, 32'h80840292,
    32'h6F711195, 32'h79947B71, 32'hEE71DD02, 32'h927C6688, 32'h7F000000, 32'h715B6B00};
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // test pins and input ports tied to idle levels
  slave_mcu_core u_dut (.mclk(mclk), .reset(reset), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .test0(1'b0), .test1(1'b0), .dackN(1'b1),
    .port1In(8'hFF), .port2In(8'hFF), .expIn(expIn), .port1Out(port1Out),
    .port2Out(port2Out), .expPort(expPort), .expCmd(expCmd), .expData(expData),
    .expStrobe(expStrobe));
  expander_model u_exp (.mclk(mclk), .reset(reset), .expPort(expPort), .expCmd(expCmd),
    .expData(expData), .expStrobe(expStrobe), .expIn(expIn), .port0Value(expSeen));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    cmpCount++;
    if (got !== exp)
    begin
      badCount++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one bus access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
    input logic [3:0] be);
    @(posedge mclk);
    address <= a;
    writedata <= d;
    byteenable <= be;
    read <= !wr;
    write <= wr;
    // no cycle count assumed: only the watchdog ends a silent wait
    do
    begin
      @(posedge mclk);
    end
    while (waitrequest !== 1'b0);
    rdVal = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  // poll for a full output buffer, then read and judge it
  task automatic expect_out(input logic [7:0] e);
    int n;
    n = 0;
    do
    begin
      bus(1'b0, REG_STAT, 32'h0, 4'hF);
      n++;
    end
    while (rdVal[ST_OBF] !== 1'b1 && n < 400);
    // a buffer that never fills counts against the run
    if (rdVal[ST_OBF] !== 1'b1)
    begin
      badCount++;
      $display("wrong value at %0t: output buffer never filled", $time);
    end
    bus(1'b0, REG_DATA, 32'h0, 4'hF);
    cmp(rdVal, {24'h0, e});
  endtask
  task automatic stopTest;
    $display("comparisons %0d mismatches %0d", cmpCount, badCount);
    if (badCount == 0 && cmpCount > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // idle registers, read-only counter, unmapped place, masked write
  task automatic check_regs;
    bus(1'b0, REG_STAT, 32'h0, 4'hF);
    cmp(rdVal, 32'h0);
    bus(1'b1, REG_PC, 32'h55, 4'hF);
    bus(1'b0, REG_PC, 32'h0, 4'hF);
    cmp(rdVal, 32'h0);
    bus(1'b0, 5'h18, 32'h0, 4'hF);
    cmp(rdVal, 32'h0);
    bus(1'b1, REG_DATA, 32'h77, 4'hE);
    bus(1'b0, REG_STAT, 32'h0, 4'hF);
    cmp(rdVal, 32'h0);
  endtask
  // program store filled while halted, then run
  task automatic load_prog;
    bus(1'b1, REG_PADDR, 32'h0, 4'hF);
    for (int j = 0; j < 136; j++)
      bus(1'b1, REG_PDATA, {24'h0, prog[j / 4][31 - 8 * (j % 4) -: 8]}, 4'hF);
    bus(1'b1, REG_PADDR, 32'h0F0, 4'hF);
    bus(1'b1, REG_PDATA, 32'h5A, 4'hF);
    bus(1'b1, REG_PADDR, 32'h310, 4'hF);
    bus(1'b1, REG_PDATA, 32'h3E, 4'hF);
    bus(1'b1, REG_CTRL, 32'h1, 4'hF);
  endtask
  // host bytes echoed back through the buffers
  task automatic check_echo;
    bus(1'b1, REG_DATA, 32'hA5, 4'hF);
    expect_out(8'hA5);
    bus(1'b0, REG_STAT, 32'h0, 4'hF);
    cmp(rdVal, 32'hA0);
    bus(1'b1, REG_STAT, 32'h3C, 4'hF);
    expect_out(8'h3C);
    bus(1'b0, REG_STAT, 32'h0, 4'hF);
    cmp(rdVal, 32'hA8);
  endtask
  // three passes of an add loop counted down in a register
  task automatic check_loop;
    expect_out(8'h15);
  endtask
  // bank one register survives a write to bank zero
  task automatic check_bank;
    expect_out(8'h55);
  endtask
  task automatic check_lookup;
    expect_out(8'h3E);
    expect_out(8'h5A);
  endtask
  // flag set by complement takes the flag branch and shows in status
  task automatic check_flags;
    expect_out(8'hC3);
    bus(1'b0, REG_STAT, 32'h0, 4'hF);
    cmp({31'h0, rdVal[ST_F0]}, 32'h1);
  endtask
  // write then AND on expander port zero, read back
  task automatic check_expander;
    expect_out(8'h08);
    cmp({28'h0, expSeen}, 32'h8);
  endtask
  // overflow branch taken once, flag gone after; port combined with immediates
  task automatic check_timer;
    expect_out(8'h77);
    cmp({24'h0, port1Out}, 32'h35);
  endtask
  // digit swap with memory at bank one pointer, then memory read back
  task automatic check_digit;
    expect_out(8'h37);
    expect_out(8'hAC);
  endtask
  // subroutine loads a value and returns past the call operand
  task automatic check_call;
    expect_out(8'h5B);
  endtask
  // low test pins: set-branch falls through, clear-branch taken
  task automatic check_pins;
    expect_out(8'h11);
    // flag lines overlay port 2 once enabled, output buffer now empty
    repeat (40) @(posedge mclk);
    cmp({24'h0, port2Out}, 32'hEF);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    badCount = 0;
    cmpCount = 0;
    reset = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = 5'h00;
    writedata = 32'h0;
    byteenable = 4'hF;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    check_regs;
    load_prog;
    check_echo;
    check_loop;
    check_bank;
    check_lookup;
    check_flags;
    check_expander;
    check_timer;
    check_digit;
    check_call;
    check_pins;
    stopTest;
  end
  // watchdog well beyond the expected run
  initial
  begin
    repeat (60000) @(posedge mclk);
    badCount++;
    stopTest;
  end
endmodule
